// ==== common/i2cmw_pkg.sv ====
package i2cmw_pkg;
  // Bus timing: one SCL period is four quarters
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned QUARTER_NS    = 2500;
  localparam int unsigned QUARTER_CYC   = (QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W         = 9;
  localparam logic [CNT_W-1:0] QUARTER_LAST = CNT_W'(QUARTER_CYC - 1);

  // Register offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_EVT  = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;

  // Control bits
  localparam int unsigned CTRL_EN    = 0;
  localparam int unsigned CTRL_TXIE  = 1;
  localparam int unsigned CTRL_START = 2;
  localparam int unsigned CTRL_STOP  = 3;
  localparam int unsigned CTRL_FLUSH = 4;

  // Status bits
  localparam int unsigned STAT_TX_DATA_EMPTY_FLAG = 0;
  localparam int unsigned STAT_ACK  = 1;
  localparam int unsigned STAT_NACK = 2;
  localparam int unsigned STAT_BUSY = 3;

  // Event bits, same layout in mask
  localparam int unsigned EVT_W    = 3;
  localparam int unsigned EVT_ACK  = 0;
  localparam int unsigned EVT_NACK = 1;
  localparam int unsigned EVT_STOP = 2;

  localparam logic       TX_DATA_EMPTY_FLAG_RST = 1'b1;
  localparam logic [2:0] BIT_MSB  = 3'h7;

  typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} i2cmw_op_t;
endpackage

// ==== common/i2cmw_bit_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface i2cmw_bit_if;
  logic                 go;
  i2cmw_pkg::i2cmw_op_t op;
  logic                 wbit;
  logic                 busy;
  logic                 done;
  logic                 rbit;
  logic                 scl_oe;
  logic                 sda_oe;
  logic                 scl_s;
  logic                 sda_s;
  modport ctl (output go, op, wbit, scl_s, sda_s, input busy, done, rbit, scl_oe, sda_oe);
  modport eng (input go, op, wbit, scl_s, sda_s, output busy, done, rbit, scl_oe, sda_oe);
endinterface
`default_nettype wire

// ==== rtl/i2cmw_bit_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2cmw_bit_engine (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Controller side
  i2cmw_bit_if.eng  bif
);

  logic                           active;
  logic [1:0]                     ph;
  logic [i2cmw_pkg::CNT_W-1:0]    cnt;
  i2cmw_pkg::i2cmw_op_t           op;
  logic                           wbit;

  // Line levels per op and quarter: {scl released, sda released}
  function automatic logic [1:0] lvl(input i2cmw_pkg::i2cmw_op_t o, input logic [1:0] p, input logic b);
    logic [1:0] r;
    r = 2'h3;
    unique case (o)
      i2cmw_pkg::OP_START: r = (p == 2'h0) ? 2'h1 : (p == 2'h1) ? 2'h3 : (p == 2'h2) ? 2'h2 : 2'h0;
      i2cmw_pkg::OP_WRITE: r = {(p == 2'h1) || (p == 2'h2), b};
      i2cmw_pkg::OP_READ:  r = {(p == 2'h1) || (p == 2'h2), 1'b1};
      i2cmw_pkg::OP_STOP:  r = (p == 2'h0) ? 2'h0 : (p == 2'h3) ? 2'h3 : 2'h2;
    endcase
    return r;
  endfunction

  logic [1:0] cur;
  assign cur      = lvl(op, ph, wbit);
  assign bif.busy = active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active     <= 1'b0;
      ph         <= 2'h0;
      cnt        <= '0;
      op         <= i2cmw_pkg::OP_START;
      wbit       <= 1'b1;
      bif.done   <= 1'b0;
      bif.rbit   <= 1'b1;
      bif.scl_oe <= 1'b0;
      bif.sda_oe <= 1'b0;
    end else begin
      bif.done <= 1'b0;
      if (!active) begin
        if (bif.go) begin
          active <= 1'b1;
          ph     <= 2'h0;
          cnt    <= '0;
          op     <= bif.op;
          wbit   <= bif.wbit;
        end
      end else begin
        bif.scl_oe <= !cur[1];
        bif.sda_oe <= !cur[0];
        // A released SCL that a slave holds low stalls the quarter
        if (!cur[1] || bif.scl_s) begin
          if (cnt == i2cmw_pkg::QUARTER_LAST) begin
            cnt <= '0;
            ph  <= ph + 2'h1;
            if (ph == 2'h1) begin
              bif.rbit <= bif.sda_s;
            end
            if (ph == 2'h3) begin
              active   <= 1'b0;
              bif.done <= 1'b1;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
    end
  end

endmodule // i2cmw_bit_engine
`default_nettype wire

// ==== rtl/i2cmw_ctrl.sv ====
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Software enables controller, then transmit interrupt.
// RULE2: Interrupt while transmit enabled and data empty.
// RULE3: Software writes address plus write bit first.
// RULE4: Start bit sends START, then loads shifter.
// RULE5: Data-empty flag sets after first bit.
// RULE6: Remaining address and direction bits shift out.
// RULE7: Low SDA in ack slot sets ack.
// RULE8: High SDA clears ack, flags not-acknowledge.
// RULE9: Software answers with stop, flush, interrupt off.
// RULE10: STOP sent, then stop and nack cleared.
// RULE11: After ack, next byte moves to shifter.
// RULE12: Controller drives data; slave drives acknowledge.
// RULE13: No START before start bit and data.
// RULE14: Empty data at ack stretches SCL low.
// RULE15: After nack, pause until stop or start.
// RULE16: Flush drops stale byte, data-empty sets.
// RULE17: Data write clears data-empty until loaded.
module i2cmw_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // I2C pins, open drain
  input  wire logic        scl_i,
  output      logic        scl_o,
  output      logic        scl_oe,
  input  wire logic        sda_i,
  output      logic        sda_o,
  output      logic        sda_oe,
  // Interrupt
  output      logic        irq
);

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BIT, ST_HOLD, ST_ACK, ST_PAUSE, ST_STOP} i2cmw_state_t;

  i2cmw_state_t                state;
  logic [7:0]                  data;
  logic [7:0]                  shift;
  logic [2:0]                  bitn;
  logic                        tx_data_empty_flag;
  logic                        ack_st;
  logic                        nack_flag;
  logic                        ctrl_en;
  logic                        ctrl_txie;
  logic                        ctrl_start;
  logic                        ctrl_stop;
  logic [i2cmw_pkg::EVT_W-1:0] evt;
  logic [i2cmw_pkg::EVT_W-1:0] mask;
  logic [i2cmw_pkg::EVT_W-1:0] evt_rd;
  logic [1:0]                  scl_sync;
  logic [1:0]                  sda_sync;
  logic                        setup;
  logic                        access;
  logic                        wr;
  logic                        wr_data;
  logic                        wr_ctrl;
  logic                        wr_flush;
  logic                        rd_evt;
  logic                        mapped;
  logic                        op_req;
  logic                        ack_ok;
  logic                        nack_ev;
  logic                        stop_ev;

  i2cmw_bit_if bif ();

  i2cmw_bit_engine u_engine (
    .pclk    (pclk),
    .presetn (presetn),
    .bif     (bif)
  );

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
    end
  end

  assign bif.scl_s = scl_sync[1];
  assign bif.sda_s = sda_sync[1];
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = bif.scl_oe;
  assign sda_oe    = bif.sda_oe; // [RULE12]

  // APB decode
  function automatic logic hit(input logic [7:0] a);
    return (a == i2cmw_pkg::ADDR_DATA) || (a == i2cmw_pkg::ADDR_STAT) ||
           (a == i2cmw_pkg::ADDR_CTRL) || (a == i2cmw_pkg::ADDR_EVT) || (a == i2cmw_pkg::ADDR_MASK);
  endfunction

  assign mapped   = hit(paddr);
  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr       = access && pwrite && mapped;
  assign wr_data  = wr && (paddr == i2cmw_pkg::ADDR_DATA);
  assign wr_ctrl  = wr && (paddr == i2cmw_pkg::ADDR_CTRL);
  assign wr_flush = wr_ctrl && pwdata[i2cmw_pkg::CTRL_FLUSH];
  assign rd_evt   = access && !pwrite && (paddr == i2cmw_pkg::ADDR_EVT);
  assign pready   = 1'b1;
  assign pslverr  = access && !mapped;

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      evt_rd <= '0;
    end else if (setup && !pwrite) begin
      prdata <= 32'h0000_0000;
      evt_rd <= '0;
      unique case (paddr)
        i2cmw_pkg::ADDR_DATA: prdata[7:0] <= data;
        i2cmw_pkg::ADDR_STAT: begin
          prdata[i2cmw_pkg::STAT_TX_DATA_EMPTY_FLAG] <= tx_data_empty_flag;
          prdata[i2cmw_pkg::STAT_ACK]  <= ack_st;
          prdata[i2cmw_pkg::STAT_NACK] <= nack_flag;
          prdata[i2cmw_pkg::STAT_BUSY] <= (state != ST_IDLE);
        end
        i2cmw_pkg::ADDR_CTRL: begin
          prdata[i2cmw_pkg::CTRL_EN]    <= ctrl_en;
          prdata[i2cmw_pkg::CTRL_TXIE]  <= ctrl_txie;
          prdata[i2cmw_pkg::CTRL_START] <= ctrl_start;
          prdata[i2cmw_pkg::CTRL_STOP]  <= ctrl_stop;
        end
        i2cmw_pkg::ADDR_EVT: begin
          prdata[i2cmw_pkg::EVT_W-1:0] <= evt;
          evt_rd                       <= evt;
        end
        i2cmw_pkg::ADDR_MASK: prdata[i2cmw_pkg::EVT_W-1:0] <= mask;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Engine events of this cycle
  assign ack_ok  = (state == ST_ACK) && bif.done && !bif.rbit;
  assign nack_ev = (state == ST_ACK) && bif.done && bif.rbit;
  assign stop_ev = (state == ST_STOP) && bif.done;

  // Control register; a write in the same cycle wins over hardware clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en    <= 1'b0;
      ctrl_txie  <= 1'b0;
      ctrl_start <= 1'b0;
      ctrl_stop  <= 1'b0;
      mask       <= '0;
    end else begin
      if (state == ST_START && bif.done) begin
        ctrl_start <= 1'b0;
      end
      if (stop_ev) begin
        ctrl_stop <= 1'b0; // [RULE10]
      end
      if (wr_ctrl) begin
        ctrl_en    <= pwdata[i2cmw_pkg::CTRL_EN];
        ctrl_txie  <= pwdata[i2cmw_pkg::CTRL_TXIE];
        ctrl_start <= pwdata[i2cmw_pkg::CTRL_START];
        ctrl_stop  <= pwdata[i2cmw_pkg::CTRL_STOP];
      end
      if (wr && paddr == i2cmw_pkg::ADDR_MASK) begin
        mask <= pwdata[i2cmw_pkg::EVT_W-1:0];
      end
    end
  end

  // Data register and empty flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data <= 8'h00;
      tx_data_empty_flag <= i2cmw_pkg::TX_DATA_EMPTY_FLAG_RST;
    end else begin
      if (state == ST_BIT && bif.done && bitn == i2cmw_pkg::BIT_MSB) begin
        tx_data_empty_flag <= 1'b1; // [RULE5]
      end
      if (wr_flush) begin
        tx_data_empty_flag <= 1'b1; // [RULE16]
      end
      if (wr_data) begin
        data <= pwdata[7:0];
        tx_data_empty_flag <= 1'b0; // [RULE17]
      end
    end
  end

  // Acknowledge status and nack flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_st    <= 1'b0;
      nack_flag <= 1'b0;
    end else begin
      if (ack_ok) begin
        ack_st <= 1'b1; // [RULE7]
      end
      if (nack_ev) begin
        ack_st    <= 1'b0; // [RULE8]
        nack_flag <= 1'b1;
      end
      if (stop_ev) begin
        nack_flag <= 1'b0; // [RULE10]
      end
    end
  end

  // Sticky events; read clears only what was read, new sets win
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= '0;
    end else begin
      evt <= (rd_evt ? (evt & ~evt_rd) : evt) |
             {stop_ev, nack_ev, ack_ok}; // [RULE8]
    end
  end

  assign irq = (ctrl_txie && tx_data_empty_flag) || |(evt & mask); // [RULE2]

  // Transaction sequencer
  assign op_req   = (state == ST_START) || (state == ST_BIT) || (state == ST_ACK) || (state == ST_STOP);
  assign bif.go   = op_req && !bif.busy && !bif.done;
  assign bif.wbit = shift[7];

  always_comb begin
    bif.op = i2cmw_pkg::OP_WRITE;
    unique case (state)
      ST_START: bif.op = i2cmw_pkg::OP_START;
      ST_ACK:   bif.op = i2cmw_pkg::OP_READ; // [RULE12]
      ST_STOP:  bif.op = i2cmw_pkg::OP_STOP;
      default:  bif.op = i2cmw_pkg::OP_WRITE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      shift <= 8'hFF;
      bitn  <= 3'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (ctrl_en && ctrl_start && !tx_data_empty_flag) begin
            state <= ST_START; // [RULE13]
          end
        end
        ST_START: begin
          if (bif.done) begin
            shift <= data; // [RULE4]
            bitn  <= i2cmw_pkg::BIT_MSB;
            state <= ST_BIT;
          end
        end
        ST_BIT: begin
          if (bif.done) begin
            shift <= {shift[6:0], 1'b1}; // [RULE6]
            bitn  <= bitn - 3'h1;
            if (bitn == 3'h0) begin
              state <= ST_HOLD;
            end
          end
        end
        ST_HOLD: begin
          if (!tx_data_empty_flag || ctrl_stop || ctrl_start) begin
            state <= ST_ACK; // [RULE14]
          end
        end
        ST_ACK: begin
          if (bif.done) begin
            if (bif.rbit) begin
              state <= ST_PAUSE;
            end else if (ctrl_stop) begin
              state <= ST_STOP;
            end else if (ctrl_start) begin
              state <= ST_IDLE;
            end else begin
              shift <= data; // [RULE11]
              bitn  <= i2cmw_pkg::BIT_MSB;
              state <= ST_BIT;
            end
          end
        end
        ST_PAUSE: begin
          if (ctrl_stop) begin
            state <= ST_STOP; // [RULE15]
          end else if (ctrl_start) begin
            state <= ST_IDLE;
          end
        end
        ST_STOP: begin
          if (bif.done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  irq_txempty_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    (ctrl_txie && tx_data_empty_flag) |-> irq)
    else $error("irq low while transmit empty and enabled");

  start_gated_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    (state != ST_START ##1 state == ST_START) |-> $past(ctrl_start && !tx_data_empty_flag && ctrl_en))
    else $error("start issued without start bit and data");

  start_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    (state == ST_START && bif.done) |=> (shift == $past(data)) && state == ST_BIT)
    else $error("shifter not loaded after start");

  first_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    (state == ST_BIT && bif.done && bitn == 3'h7 && !wr_data) |=> tx_data_empty_flag)
    else $error("data empty not set after first bit");

  bits_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (state == ST_BIT && bif.done && bitn != 3'h0) |=> state == ST_BIT ##1 bif.busy)
    else $error("remaining bits not shifted");

  ack_seen_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    ack_ok |=> ack_st && evt[i2cmw_pkg::EVT_ACK])
    else $error("ack not recorded");

  nack_seen_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    nack_ev |=> !ack_st && nack_flag && evt[i2cmw_pkg::EVT_NACK] && state == ST_PAUSE)
    else $error("nack not recorded");

  stop_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    (stop_ev && !wr_ctrl) |=> !ctrl_stop && !nack_flag && state == ST_IDLE)
    else $error("stop or nack not cleared after stop");

  next_byte_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    (ack_ok && !ctrl_stop && !ctrl_start) |=> state == ST_BIT && shift == $past(data))
    else $error("next byte not loaded");

  ack_release_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    (state == ST_ACK)[*3] |-> !sda_oe)
    else $error("sda driven in ack slot");

  stretch_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE14]
    (state == ST_HOLD && tx_data_empty_flag && !ctrl_stop && !ctrl_start) |-> scl_oe ##1 state == ST_HOLD)
    else $error("scl not held during stretch");

  nack_pause_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (state == ST_PAUSE && !ctrl_stop && !ctrl_start) |=> state == ST_PAUSE)
    else $error("left pause without stop or start");

  flush_empty_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    (wr_flush && !wr_data) |=> tx_data_empty_flag)
    else $error("flush did not empty data");

  write_full_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    wr_data |=> !tx_data_empty_flag && data == $past(pwdata[7:0]))
    else $error("data write did not clear empty");

endmodule // i2cmw_ctrl
`default_nettype wire

// ==== tb/i2cmw_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2cmw_slave_model (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Behaviour
  input  wire logic       ack_en,
  input  wire logic       stretch,
  // Pulls and observation
  output var  logic       scl_pull,
  output var  logic       sda_pull,
  output var  logic [7:0] last_byte,
  output var  int         bit_cnt,
  output var  int         byte_cnt,
  output var  int         start_cnt,
  output var  int         stop_cnt
);
  logic [7:0] shreg;
  initial begin
    {scl_pull, sda_pull, last_byte, shreg} = '0;
    {bit_cnt, byte_cnt, start_cnt, stop_cnt} = '0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    start_cnt++;
    bit_cnt = 0;
  end
  // Only a rise that closes a started frame counts, not the power-up settle
  always @(posedge sda) if (scl === 1'b1 && start_cnt > stop_cnt) stop_cnt++;
  // Shift in MSB first
  always @(posedge scl) begin
    if (bit_cnt < 8) begin
      shreg = {shreg[6:0], sda};
      bit_cnt++;
      if (bit_cnt == 8) begin
        last_byte = shreg;
        byte_cnt++;
      end
    end else begin
      bit_cnt = 9;
    end
  end
  always @(negedge scl) begin
    if (bit_cnt == 8) begin
      sda_pull = ack_en;
    end else if (bit_cnt == 9) begin
      sda_pull = 1'b0;
      bit_cnt = 0;
    end
    if (stretch) begin
      scl_pull = 1'b1;
      #1000;
      scl_pull = 1'b0;
    end
  end
endmodule // i2cmw_slave_model
`default_nettype wire

// ==== tb/i2c_master_write_7bit_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module i2c_master_write_7bit_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq, ack_en, stretch, scl_pull, sda_pull;
  logic [7:0]  paddr, last_byte;
  logic [31:0] pwdata, prdata, rd;
  int          bit_cnt, byte_cnt, start_cnt, stop_cnt, errors, tests_run;
  wire logic   scl_w = (scl_oe ? scl_o : 1'b1) & ~scl_pull;
  wire logic   sda_w = (sda_oe ? sda_o : 1'b1) & ~sda_pull;

  i2cmw_ctrl i2cmw_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  i2cmw_slave_model i2cmw_slave_model_inst (.scl(scl_w), .sda(sda_w), .ack_en(ack_en),
    .stretch(stretch), .scl_pull(scl_pull), .sda_pull(sda_pull), .last_byte(last_byte),
    .bit_cnt(bit_cnt), .byte_cnt(byte_cnt), .start_cnt(start_cnt), .stop_cnt(stop_cnt));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    `CHK(n, e, rd)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  initial begin
    repeat (80000) @(posedge pclk);
    errors++;
    conclude();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    ack_en = 1'b1;
    stretch = 1'b0;
    errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(i2cmw_pkg::ADDR_STAT, 32'h1, "stat_rst");
    rd_chk(i2cmw_pkg::ADDR_CTRL, 32'h0, "ctrl_rst");
    rd_chk(i2cmw_pkg::ADDR_MASK, 32'h0, "mask_rst");
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped_err", 1'b1, err)
    `CHK("unmapped_data", 32'h0, rd)
    apb(1'b1, i2cmw_pkg::ADDR_MASK, 32'h2);
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h1);
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h3);
    settle(1);
    `CHK("irq_empty", 1'b1, irq)
    // Start requested with nothing to send
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h7);
    settle(2000);
    `CHK("early_start", 0, start_cnt)
    apb(1'b1, i2cmw_pkg::ADDR_DATA, 32'hA0);
    settle(1);
    `CHK("irq_full", 1'b0, irq)
    // Waits end only by the event or by the watchdog
    while (irq !== 1'b1) settle(1);
    `CHK("start_cnt", 1, start_cnt)
    `CHK("bits_at_empty", 1, bit_cnt)
    apb(1'b1, i2cmw_pkg::ADDR_DATA, 32'h3C);
    while (byte_cnt != 1) settle(1);
    `CHK("addr_byte", 8'hA0, last_byte)
    while (!(byte_cnt == 2 && bit_cnt == 8)) settle(1);
    `CHK("data_byte", 8'h3C, last_byte)
    apb(1'b0, i2cmw_pkg::ADDR_STAT, 32'h0);
    `CHK("stat_ack", 3'h3, rd[2:0])
    // Nothing queued: clock must stay low before the ack slot
    settle(4000);
    `CHK("stretch_scl", 1'b0, scl_w)
    `CHK("stretch_bits", 8, bit_cnt)
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h9);
    while (stop_cnt != 1) settle(1);
    settle(1500);
    `CHK("irq_masked", 1'b0, irq)
    `CHK("idle_sda", 1'b1, sda_w)
    rd_chk(i2cmw_pkg::ADDR_CTRL, 32'h1, "ctrl_after_stop");
    rd_chk(i2cmw_pkg::ADDR_EVT, 32'h5, "evt_ack_stop");
    rd_chk(i2cmw_pkg::ADDR_EVT, 32'h0, "evt_cleared");
    // Slow slave that refuses its address
    ack_en <= 1'b0;
    stretch <= 1'b1;
    apb(1'b1, i2cmw_pkg::ADDR_DATA, 32'hA2);
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h7);
    while (irq !== 1'b1) settle(1);
    apb(1'b1, i2cmw_pkg::ADDR_DATA, 32'h55);
    settle(1);
    while (irq !== 1'b1) settle(1);
    apb(1'b0, i2cmw_pkg::ADDR_STAT, 32'h0);
    `CHK("stat_nack", 3'h4, rd[2:0])
    settle(3000);
    `CHK("pause_stop", 1, stop_cnt)
    `CHK("pause_scl", 1'b0, scl_w)
    apb(1'b1, i2cmw_pkg::ADDR_CTRL, 32'h19);
    while (stop_cnt != 2) settle(1);
    settle(1500);
    apb(1'b0, i2cmw_pkg::ADDR_STAT, 32'h0);
    `CHK("stat_flushed", 3'h1, rd[2:0])
    rd_chk(i2cmw_pkg::ADDR_CTRL, 32'h1, "ctrl_after_nack");
    `CHK("stale_unsent", 3, byte_cnt)
    rd_chk(i2cmw_pkg::ADDR_EVT, 32'h6, "evt_nack_stop");
    settle(1);
    `CHK("irq_cleared", 1'b0, irq)
    conclude();
  end
endmodule // i2c_master_write_7bit_tb
`default_nettype wire
